/* bsl_regs.svh */
// Constants for the boot strap latch decoder
`ifndef BSL_REGS_SVH
`define BSL_REGS_SVH
`define BSL_NUM_STRAPS     18
`define BSL_ORDER_BIT      0
`define BSL_SRC_LSB        1
`define BSL_SRC_MSB        4
`define BSL_OPT_LSB        5
`define BSL_OPT_MSB        10
`define BSL_REF_LSB        11
`define BSL_REF_MSB        13
`define BSL_ROLE_LSB       14
`define BSL_ROLE_MSB       15
`define BSL_PCIE_ON_BIT    16
`define BSL_SPARE_BIT      17
`define BSL_STRAP_RST      18'h00000
`define BSL_ROLE_RSVD      2'h3
`endif

/* bsl_pkg.sv */
// Types for the boot strap latch decoder
package bsl_pkg;
   typedef enum logic [3:0] {
      BSL_SRC_SLEEP    = 4'h0,
      BSL_SRC_SRIO     = 4'h1,
      BSL_SRC_ETH      = 4'h2,
      BSL_SRC_NAND     = 4'h3,
      BSL_SRC_PCIE     = 4'h4,
      BSL_SRC_I2C_MST  = 4'h5,
      BSL_SRC_I2C_SLV  = 4'h6,
      BSL_SRC_SPI      = 4'h7,
      BSL_SRC_CHIPLINK = 4'h8,
      BSL_SRC_UART     = 4'h9,
      BSL_SRC_INVALID  = 4'hf
   } bsl_src_t;

   typedef enum logic [1:0] {
      BSL_ROLE_EP     = 2'h0,
      BSL_ROLE_LEG_EP = 2'h1,
      BSL_ROLE_RC     = 2'h2,
      BSL_ROLE_RSVD   = 2'h3
   } bsl_role_t;

   // Idle in reset, let the synchroniser refill, capture once, then hold
   typedef enum logic [1:0] {
      BSL_ST_RESET   = 2'h0,
      BSL_ST_SETTLE  = 2'h1,
      BSL_ST_CAPTURE = 2'h3,
      BSL_ST_HOLD    = 2'h2
   } bsl_state_t;
endpackage : bsl_pkg

/* bsl_sync.sv */
// Two flip-flop synchroniser for one strap pin
`timescale 1ns/1ps
module bsl_sync (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic srst_i,
   // Pin and result
   input  wire logic pin_i,
   output logic      pin_o
);
   logic meta_q;
   logic sync_q;

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end

   assign pin_o = sync_q;
endmodule : bsl_sync

/* bsl_boot_strap_latch.sv */
// Boot strap latch and decoder
// Function
// [R01] All 18 straps are captured once, on reset release, never otherwise.
// [R02] Any reset cause reaching srst_i triggers a capture on release.
// [R03] Byte order bit: 0 big endian, 1 little endian.
// [R04] Four-bit boot source field decoded to one of ten sources.
// [R05] Six-bit option field latched with source, meaning depends on source.
// [R06] Three-bit field gives reference clock frequency, in kHz.
// [R07] Two-bit PCIe role: endpoint, legacy endpoint, root complex; 11 reserved.
// [R08] PCIe subsystem bit: 0 disabled, 1 enabled.
// [R09] Latched values hold until the next reset release; the code clears them while srst_i is high.
`timescale 1ns/1ps
`include "bsl_regs.svh"
module bsl_boot_strap_latch (
   // Clock and reset
   input  wire logic                          clk_sys_i,
   input  wire logic                          srst_i,
   // Board switches
   input  wire logic [`BSL_NUM_STRAPS-1:0]   strap_i,
   // Decoded configuration
   output logic                               cfg_valid_o,
   output logic                               byte_order_select_o,
   output logic                               little_endian_o,
   output bsl_pkg::bsl_src_t                  boot_src_o,
   output logic [3:0]                         boot_src_raw_o,
   output logic [5:0]                         boot_opt_o,
   output logic [2:0]                         ref_clk_sel_o,
   output logic [18:0]                        ref_clk_khz_o,
   output bsl_pkg::bsl_role_t                 pcie_role_select_o,
   output logic                               pcie_role_rsvd_o,
   output logic                               pcie_subsystem_on_o
);
   typedef struct packed {
      bsl_pkg::bsl_state_t         st;
      logic                        valid;
      logic [`BSL_NUM_STRAPS-1:0]  raw;
      bsl_pkg::bsl_src_t           src;
      logic [18:0]                 khz;
      logic                        role_rsvd;
   } bsl_state_s_t;

   bsl_state_s_t                 s_q;
   bsl_state_s_t                 s_d;
   logic [`BSL_NUM_STRAPS-1:0]   strap_sync;

   // Pins are asynchronous to the core clock
   genvar g;
   generate
      for (g = 0; g < `BSL_NUM_STRAPS; g++)
      begin : g_sync
         bsl_sync u_sync (
            .clk_sys_i (clk_sys_i),
            .srst_i    (srst_i),
            .pin_i     (strap_i[g]),
            .pin_o     (strap_sync[g])
         );
      end
   endgenerate

   function automatic bsl_pkg::bsl_src_t dec_src(input logic [3:0] f);
      bsl_pkg::bsl_src_t r;
      r = bsl_pkg::BSL_SRC_INVALID;
      // Exact codes only; 4'ha and 4'he repeat ETH and SPI, 4'hd selects I2C master
      case (f)
         4'h0: r = bsl_pkg::BSL_SRC_SLEEP;
         4'h1: r = bsl_pkg::BSL_SRC_SRIO;
         4'h2: r = bsl_pkg::BSL_SRC_ETH;
         4'ha: r = bsl_pkg::BSL_SRC_ETH;
         4'h3: r = bsl_pkg::BSL_SRC_NAND;
         4'h4: r = bsl_pkg::BSL_SRC_PCIE;
         4'h5: r = bsl_pkg::BSL_SRC_I2C_SLV;
         4'hd: r = bsl_pkg::BSL_SRC_I2C_MST;
         4'h6: r = bsl_pkg::BSL_SRC_SPI;
         4'he: r = bsl_pkg::BSL_SRC_SPI;
         4'h7: r = bsl_pkg::BSL_SRC_CHIPLINK;
         4'h8: r = bsl_pkg::BSL_SRC_UART;
         default: r = bsl_pkg::BSL_SRC_INVALID;
      endcase
      return r;
   endfunction : dec_src

   function automatic logic [18:0] dec_khz(input logic [2:0] f);
      logic [18:0] r;
      r = 19'h00000;
      // Rounded to the nearest kHz
      case (f)
         3'h0: r = 19'd50000;
         3'h1: r = 19'd66670;
         3'h2: r = 19'd80000;
         3'h3: r = 19'd100000;
         3'h4: r = 19'd156250;
         3'h5: r = 19'd250000;
         3'h6: r = 19'd312500;
         default: r = 19'd122880;
      endcase
      return r;
   endfunction : dec_khz

   always_comb
   begin
      s_d = s_q;
      case (s_q.st)
         bsl_pkg::BSL_ST_RESET:
         begin
            s_d.st = bsl_pkg::BSL_ST_SETTLE;
         end
         bsl_pkg::BSL_ST_SETTLE:
         begin
            // Synchroniser was cleared by reset; its second stage refills now
            s_d.st = bsl_pkg::BSL_ST_CAPTURE;
         end
         bsl_pkg::BSL_ST_CAPTURE:
         begin
            // Synchroniser now holds pins from the release edge
            s_d.raw   = strap_sync; // [R01] [R02]
            s_d.src   = dec_src(strap_sync[`BSL_SRC_MSB:`BSL_SRC_LSB]); // [R04]
            s_d.khz   = dec_khz(strap_sync[`BSL_REF_MSB:`BSL_REF_LSB]); // [R06]
            s_d.role_rsvd = (strap_sync[`BSL_ROLE_MSB:`BSL_ROLE_LSB]
                             == `BSL_ROLE_RSVD); // [R07]
            s_d.valid = 1'b1;
            s_d.st    = bsl_pkg::BSL_ST_HOLD;
         end
         bsl_pkg::BSL_ST_HOLD:
         begin
            s_d.st = bsl_pkg::BSL_ST_HOLD; // [R09]
         end
         default:
         begin
            s_d.st = bsl_pkg::BSL_ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         // State, valid and every captured field clear; old values would be stale anyway
         s_q.st        <= bsl_pkg::BSL_ST_RESET;
         s_q.valid     <= 1'b0;
         s_q.raw       <= `BSL_STRAP_RST;
         s_q.src       <= bsl_pkg::BSL_SRC_SLEEP;
         s_q.khz       <= 19'h00000;
         s_q.role_rsvd <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         cfg_valid_o         <= 1'b0;
         byte_order_select_o <= 1'b0;
         little_endian_o     <= 1'b0;
         boot_src_o          <= bsl_pkg::BSL_SRC_SLEEP;
         boot_src_raw_o      <= 4'h0;
         boot_opt_o          <= 6'h00;
         ref_clk_sel_o       <= 3'h0;
         ref_clk_khz_o       <= 19'h00000;
         pcie_role_select_o  <= bsl_pkg::BSL_ROLE_EP;
         pcie_role_rsvd_o    <= 1'b0;
         pcie_subsystem_on_o <= 1'b0;
      end
      else
      begin
         cfg_valid_o         <= s_q.valid;
         byte_order_select_o <= s_q.raw[`BSL_ORDER_BIT]; // [R03]
         little_endian_o     <= s_q.valid & s_q.raw[`BSL_ORDER_BIT]; // [R03]
         boot_src_o          <= s_q.src; // [R04]
         boot_src_raw_o      <= s_q.raw[`BSL_SRC_MSB:`BSL_SRC_LSB];
         boot_opt_o          <= s_q.raw[`BSL_OPT_MSB:`BSL_OPT_LSB]; // [R05]
         ref_clk_sel_o       <= s_q.raw[`BSL_REF_MSB:`BSL_REF_LSB]; // [R06]
         ref_clk_khz_o       <= s_q.khz; // [R06]
         pcie_role_select_o  <= bsl_pkg::bsl_role_t'(
                                s_q.raw[`BSL_ROLE_MSB:`BSL_ROLE_LSB]); // [R07]
         pcie_role_rsvd_o    <= s_q.role_rsvd; // [R07]
         // Disabled until a valid capture exists
         pcie_subsystem_on_o <= s_q.valid
                                & s_q.raw[`BSL_PCIE_ON_BIT]; // [R08]
      end
   end
endmodule : bsl_boot_strap_latch

/* bsl_board.sv */
// Board switch bank and reset sources
`timescale 1ns/1ps
module bsl_board (
   // Clock
   input  wire logic        clk_sys_i,
   // Switches; causes are power, button, controller
   input  wire logic [17:0] sw_i,
   input  wire logic [2:0]  cause_i,
   // Toward the latch
   output logic [17:0]      strap_o,
   output logic             srst_o
);
   assign strap_o = sw_i;
   // Registered so reset leaves on a clean edge
   always_ff @(posedge clk_sys_i)
   begin
      srst_o <= |cause_i;
   end
endmodule : bsl_board

/* bsl_assertions.sv */
// Assertion checker for the boot strap latch
`timescale 1ns/1ps
module bsl_assertions (
   input wire logic               clk_sys_i,
   input wire logic               srst_i,
   input wire logic               cfg_valid_o,
   input wire logic               byte_order_select_o,
   input wire logic               little_endian_o,
   input wire bsl_pkg::bsl_src_t  boot_src_o,
   input wire logic [3:0]         boot_src_raw_o,
   input wire logic [5:0]         boot_opt_o,
   input wire logic [2:0]         ref_clk_sel_o,
   input wire logic [18:0]        ref_clk_khz_o,
   input wire bsl_pkg::bsl_role_t pcie_role_select_o,
   input wire logic               pcie_role_rsvd_o,
   input wire logic               pcie_subsystem_on_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (srst_i);
   sequence s_release;
      $fell(srst_i);
   endsequence
   sequence s_settle;
      (!srst_i) [*4];
   endsequence
   property p_rst_clear;
      s_release |-> !cfg_valid_o && !little_endian_o && !pcie_subsystem_on_o;
   endproperty
   property p_capture;
      s_release ##1 s_settle |-> cfg_valid_o;
   endproperty
   property p_hold;
      cfg_valid_o && $past(cfg_valid_o) |-> $stable(boot_src_raw_o)
         && $stable(boot_opt_o) && $stable(pcie_role_select_o);
   endproperty
   property p_endian;
      little_endian_o == (cfg_valid_o && byte_order_select_o);
   endproperty
   property p_src_nand;
      cfg_valid_o && boot_src_raw_o == 4'h3 |->
         boot_src_o == bsl_pkg::BSL_SRC_NAND;
   endproperty
   property p_ref_top;
      cfg_valid_o && ref_clk_sel_o == 3'h7 |-> ref_clk_khz_o == 19'h1e000;
   endproperty
   property p_role_rsvd;
      pcie_role_rsvd_o == (pcie_role_select_o == bsl_pkg::BSL_ROLE_RSVD);
   endproperty
   property p_pcie_on;
      pcie_subsystem_on_o |-> cfg_valid_o;
   endproperty
   a_rst_clear : assert property (p_rst_clear) else $error("not clear");
   a_capture   : assert property (p_capture) else $error("no capture");
   a_hold      : assert property (p_hold) else $error("field moved");
   a_endian    : assert property (p_endian) else $error("bad endian");
   a_src_nand  : assert property (p_src_nand) else $error("bad src");
   a_ref_top   : assert property (p_ref_top) else $error("bad ref");
   a_role_rsvd : assert property (p_role_rsvd) else $error("bad role");
   a_pcie_on   : assert property (p_pcie_on) else $error("bad pcie");
endmodule : bsl_assertions
bind bsl_boot_strap_latch bsl_assertions u_chk (.clk_sys_i, .srst_i,
   .cfg_valid_o, .byte_order_select_o, .little_endian_o, .boot_src_o,
   .boot_src_raw_o, .boot_opt_o, .ref_clk_sel_o, .ref_clk_khz_o,
   .pcie_role_select_o, .pcie_role_rsvd_o, .pcie_subsystem_on_o);

/* boot_strap_latch_decoder_test.sv */
// Self-checking bench for the boot strap latch
`timescale 1ns/1ps
module boot_strap_latch_decoder_test;
   logic               clk_sys_i = 1'b0;
   logic [17:0]        sw_q      = 18'h00000;
   logic [2:0]         cause_q   = 3'h1;
   logic [17:0]        strap_i;
   logic               srst_i, cfg_valid_o, byte_order_select_o;
   logic               little_endian_o, pcie_role_rsvd_o, pcie_subsystem_on_o;
   bsl_pkg::bsl_src_t  boot_src_o;
   bsl_pkg::bsl_role_t pcie_role_select_o;
   logic [3:0]         boot_src_raw_o;
   logic [5:0]         boot_opt_o;
   logic [2:0]         ref_clk_sel_o;
   logic [18:0]        ref_clk_khz_o;
   int                 err_total  = 0;
   int                 num_checks = 0;
   // Source codes in enum order; top bit is a don't-care in 4'ha and 4'he, selects I2C master in 4'hd
   logic [3:0]         src_c [10] = '{4'h0, 4'h1, 4'ha, 4'h3, 4'h4,
                                      4'hd, 4'h5, 4'he, 4'h7, 4'h8};
   logic [18:0]        khz_c [8] = '{19'h0c350, 19'h1046e, 19'h13880,
      19'h186a0, 19'h2625a, 19'h3d090, 19'h4c4b4, 19'h1e000};
   bsl_board u_board (.clk_sys_i, .sw_i(sw_q), .cause_i(cause_q),
      .strap_o(strap_i), .srst_o(srst_i));
   bsl_boot_strap_latch DUT (.clk_sys_i, .srst_i, .strap_i, .cfg_valid_o,
      .byte_order_select_o, .little_endian_o, .boot_src_o, .boot_src_raw_o,
      .boot_opt_o, .ref_clk_sel_o, .ref_clk_khz_o, .pcie_role_select_o,
      .pcie_role_rsvd_o, .pcie_subsystem_on_o);
   always #5 clk_sys_i = ~clk_sys_i;
   task automatic end_sim;
      if (err_total == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Straps change in the same cycle as one reset cause pulse, well before release
   task automatic reboot(input logic [2:0] cause, input logic [17:0] sw);
      @(posedge clk_sys_i);
      sw_q    <= sw;
      cause_q <= cause;
      repeat (3) @(posedge clk_sys_i);
      cause_q <= 3'h0;
      repeat (2) @(posedge clk_sys_i);
      for (int n = 0; n < 8 && cfg_valid_o !== 1'b1; n++)
         @(posedge clk_sys_i);
      chk(cfg_valid_o, 1'b1);
   endtask : reboot
   task automatic fields(input logic [17:0] sw, input logic [3:0] src,
                         input logic [18:0] khz);
      #1;
      chk(byte_order_select_o, sw[0]);
      chk(little_endian_o, sw[0]);
      chk(boot_src_raw_o, sw[4:1]);
      chk(boot_src_o, src);
      chk(boot_opt_o, sw[10:5]);
      chk(ref_clk_sel_o, sw[13:11]);
      chk(ref_clk_khz_o, khz);
      chk(pcie_role_select_o, sw[15:14]);
      chk(pcie_role_rsvd_o, &sw[15:14]);
      chk(pcie_subsystem_on_o, sw[16]);
   endtask : fields
   initial
   begin
      logic [17:0] sw;
      repeat (6) @(posedge clk_sys_i);
      cause_q <= 3'h0;
      for (int i = 0; i < 10; i++)
      begin
         sw = {i[0], i[1], 2'(i % 3), i[2:0], 6'(i * 5), src_c[i], i[0]};
         reboot(3'(1 << (i % 3)), sw);
         fields(sw, 4'(i), khz_c[i[2:0]]);
      end
      sw = 18'h00012;
      reboot(3'h2, sw);
      fields(sw, 4'hf, 19'h0c350);
      sw = 18'h3c001;
      reboot(3'h4, sw);
      fields(sw, 4'h0, 19'h0c350);
      sw_q <= ~sw;
      repeat (6) @(posedge clk_sys_i);
      fields(sw, 4'h0, 19'h0c350);
      end_sim();
   end
   // About 130 cycles expected; 2000 cycles means a hang
   initial
   begin
      #20000;
      err_total++;
      end_sim();
   end
endmodule : boot_strap_latch_decoder_test
